// [verilog/csd_status_ctrl.sv]
// Summary of operation
// - status outputs valid only after good start-up
// - power good low when input in window
// - mirror select makes power good follow button
// - charging and enable hold interrupt low
// - enable zero hides charge status
// - charge done or disabled releases interrupt
// - recharge indicated same as first charge
// - each fault starts a 128 us pulse; a fault mid pulse restarts it
// - battery only, disable low gives high-z mode
// - aux output kept, control pin still works
// - disable input pulled down when floating
// - input present, disable low enables charging
// - input present, disable high stops charging
// - buck switching gated by test enable bit
// - enable: reference, soft-start, switching, ramp
// - disable: shutdown and discharge output
// - system rail re-enabled by input or button
// - range and code fields set system voltage
// - timer fault pulses, clears on toggle
module csd_status_ctrl #(
  parameter int unsigned BTN_RESET_CYCLES = csd_pkg::BTN_RESET_CYC,
  parameter int unsigned SYS_CODE_W       = 4
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // input power comparators
  input  wire logic                  vin_above_uvlo,
  input  wire logic                  vin_above_bat_slp,
  input  wire logic                  vin_below_ovp,
  input  wire logic                  bat_present,
  // start-up result
  input  wire logic                  startup_done,
  input  wire logic                  startup_fault,
  // charger status and events
  input  wire logic                  charging,
  input  wire logic                  recharging,
  input  wire logic                  fault_event,
  input  wire logic                  safety_timer_fault,
  // configuration bits
  input  wire logic                  pg_mirror_sel,
  input  wire logic                  charge_int_en,
  input  wire logic                  buck_out_en,
  input  wire logic [1:0]            sys_range_sel,
  input  wire logic [SYS_CODE_W-1:0] code_a,
  // pins
  input  wire logic                  button_in_n,
  input  wire logic                  chip_disable_n,
  input  wire logic                  chip_disable_floating,
  input  wire logic                  aux_switch_ctrl,
  input  wire logic                  sys_disable_req,
  // open-drain outputs, enable high while pulling low
  output logic                       power_good_n_o,
  output logic                       power_good_n_oe,
  output logic                       host_int_n_o,
  output logic                       host_int_n_oe,
  // power-stage controls
  output logic                       charge_en,
  output logic                       hiz_mode,
  output logic                       mid_rail_en,
  output logic                       system_rail_en,
  output logic                       bat_disch_on,
  output logic                       aux_output_en,
  output logic                       ref_en,
  output logic                       soft_start,
  output logic                       buck_switch_node_en,
  output logic                       buck_disch,
  output logic [1:0]                 sys_range_out,
  output logic [SYS_CODE_W-1:0]      sys_code_out,
  output logic                       safety_fault_latched
);
  logic                  status_valid_r;   // start-up reached good state
  logic                  int_block_r;      // start-up ended in fault
  logic                  cd_eff;           // disable pin after pull-down
  logic                  vin_good;         // input within window
  logic                  cd_prev_r;        // for toggle detect
  logic                  vin_prev_r;       // for toggle detect
  logic                  fault_evt;        // new fault this cycle, after good start-up
  logic                  pulse_busy;       // fault pulse running
  logic                  sys_off_r;        // system rail held off
  logic [22:0]           btn_cnt_r;        // button low hold counter
  logic [15:0]           seq_cnt_r;        // buck sequencer timer
  logic                  buck_req;         // buck should run
  csd_pkg::csd_buck_st_t bk_r;             // buck state
  csd_pkg::csd_buck_st_t bk_nxt;           // buck next state

  // refuse parameter values the counters and fields cannot hold
  if (BTN_RESET_CYCLES < 1 || BTN_RESET_CYCLES >= (1 << 23))
  begin
    $error("csd_status_ctrl: BTN_RESET_CYCLES out of range");
  end
  if (SYS_CODE_W < 1 || SYS_CODE_W > 8)
  begin
    $error("csd_status_ctrl: SYS_CODE_W out of range");
  end

  // floating pin reads low through the weak pull-down
  assign cd_eff   = chip_disable_n && !chip_disable_floating;
  assign vin_good = vin_above_uvlo && vin_above_bat_slp && vin_below_ovp;

  // start-up qualification; a fault start blocks interrupts until reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_valid_r <= 1'b0;
      int_block_r    <= 1'b0;
    end
    else if (!status_valid_r && !int_block_r)
    begin
      if (startup_fault)
        int_block_r <= 1'b1;
      else if (startup_done)
        status_valid_r <= 1'b1;
    end
  end

  // toggle history for fault clearing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cd_prev_r  <= 1'b0;
      vin_prev_r <= 1'b0;
    end
    else
    begin
      cd_prev_r  <= cd_eff;
      vin_prev_r <= vin_good;
    end
  end

  // safety-timer fault latch; a new fault wins over a same-cycle toggle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      safety_fault_latched <= 1'b0;
    else if (safety_timer_fault)
      safety_fault_latched <= 1'b1;
    else if ((cd_eff != cd_prev_r) || (vin_good != vin_prev_r))
      safety_fault_latched <= 1'b0;
  end

  // only the rising edge of a safety fault counts as a new event
  assign fault_evt = status_valid_r &&
                     (fault_event || (safety_timer_fault && !safety_fault_latched));

  csd_pulse_timer #(
    .CYCLES (csd_pkg::FAULT_PULSE_CYC),
    .WIDTH  (12)
  ) u_pulse (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (fault_evt),
    .busy    (pulse_busy)
  );

  // power good pin: window detect or mirrored button
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      power_good_n_oe <= 1'b0;
    else if (!status_valid_r)
      power_good_n_oe <= 1'b0;
    else if (pg_mirror_sel)
      power_good_n_oe <= !button_in_n;
    else
      power_good_n_oe <= vin_good;
  end

  // open-drain: data always low, only the enable moves
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_good_n_o <= 1'b0;
      host_int_n_o   <= 1'b0;
    end
    else
    begin
      power_good_n_o <= 1'b0;
      host_int_n_o   <= 1'b0;
    end
  end

  // interrupt pin: fault pulse overrides, then charge status
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      host_int_n_oe <= 1'b0;
    else if (!status_valid_r)
      host_int_n_oe <= 1'b0;
    // busy alone, so the pin stays low exactly one pulse length, not one more
    else if (pulse_busy)
      host_int_n_oe <= 1'b1;
    else if (charge_int_en && charge_en && (charging || recharging))
      host_int_n_oe <= 1'b1;
    else
      host_int_n_oe <= 1'b0;
  end

  // charge enable and high-z mode from the disable pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      charge_en    <= 1'b0;
      hiz_mode     <= 1'b0;
      bat_disch_on <= 1'b0;
      mid_rail_en  <= 1'b0;
    end
    else
    begin
      // a latched timer fault keeps charging off until cleared
      charge_en    <= vin_good && !cd_eff && !safety_fault_latched;
      hiz_mode     <= !vin_good && bat_present && !cd_eff;
      bat_disch_on <= !vin_good && bat_present && !cd_eff;
      mid_rail_en  <= vin_good || bat_present;
    end
  end

  // aux output follows its control pin in every mode, so state persists
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      aux_output_en <= 1'b0;
    else
      aux_output_en <= aux_switch_ctrl;
  end

  // button hold counter for re-enabling the system rail
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      btn_cnt_r <= '0;
    else if (button_in_n)
      btn_cnt_r <= '0;
    else if (btn_cnt_r != 23'(BTN_RESET_CYCLES))
      btn_cnt_r <= btn_cnt_r + 1'b1;
  end

  // system rail off latch: only input power or long press revives it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sys_off_r <= 1'b0;
    else if (vin_good && !vin_prev_r)
      sys_off_r <= 1'b0;
    else if (btn_cnt_r == 23'(BTN_RESET_CYCLES))
      sys_off_r <= 1'b0;
    else if (sys_disable_req)
      sys_off_r <= 1'b1;
  end

  // test-only enable gates the converter along with the rail latch
  assign buck_req = buck_out_en && !sys_off_r;

  // buck sequencer next state
  always_comb
  begin
    bk_nxt = bk_r;
    case (bk_r)
      csd_pkg::CSD_BK_OFF:
        if (buck_req)
          bk_nxt = csd_pkg::CSD_BK_REF;
      csd_pkg::CSD_BK_REF:
        if (!buck_req)
          bk_nxt = csd_pkg::CSD_BK_DISCH;
        else if (seq_cnt_r == 16'h0000)
          bk_nxt = csd_pkg::CSD_BK_SOFT;
      csd_pkg::CSD_BK_SOFT:
        if (!buck_req)
          bk_nxt = csd_pkg::CSD_BK_DISCH;
        else if (seq_cnt_r == 16'h0000)
          bk_nxt = csd_pkg::CSD_BK_RUN;
      csd_pkg::CSD_BK_RUN:
        if (!buck_req)
          bk_nxt = csd_pkg::CSD_BK_DISCH;
      csd_pkg::CSD_BK_DISCH:
        // full discharge before restart so the ramp starts at zero
        if (seq_cnt_r == 16'h0000)
          bk_nxt = csd_pkg::CSD_BK_OFF;
      default:
        bk_nxt = csd_pkg::CSD_BK_OFF;
    endcase
  end

  // buck state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bk_r <= csd_pkg::CSD_BK_OFF;
    else
      bk_r <= bk_nxt;
  end

  // phase timer, loaded on every state change
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      seq_cnt_r <= '0;
    else if (bk_nxt != bk_r)
    begin
      case (bk_nxt)
        csd_pkg::CSD_BK_REF:   seq_cnt_r <= 16'(csd_pkg::REF_UP_CYC - 1);
        csd_pkg::CSD_BK_SOFT:  seq_cnt_r <= 16'(csd_pkg::SOFTSTART_CYC - 1);
        csd_pkg::CSD_BK_DISCH: seq_cnt_r <= 16'(csd_pkg::DISCH_CYC - 1);
        default:               seq_cnt_r <= '0;
      endcase
    end
    else if (seq_cnt_r != '0)
      seq_cnt_r <= seq_cnt_r - 1'b1;
  end

  // buck controls registered from next state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_en              <= 1'b0;
      soft_start          <= 1'b0;
      buck_switch_node_en <= 1'b0;
      buck_disch          <= 1'b0;
      system_rail_en      <= 1'b0;
    end
    else
    begin
      ref_en              <= (bk_nxt != csd_pkg::CSD_BK_OFF) &&
                             (bk_nxt != csd_pkg::CSD_BK_DISCH);
      soft_start          <= (bk_nxt == csd_pkg::CSD_BK_SOFT);
      buck_switch_node_en <= (bk_nxt == csd_pkg::CSD_BK_SOFT) ||
                             (bk_nxt == csd_pkg::CSD_BK_RUN);
      buck_disch          <= (bk_nxt == csd_pkg::CSD_BK_DISCH);
      system_rail_en      <= (bk_nxt == csd_pkg::CSD_BK_RUN);
    end
  end

  // output voltage setting passed to the converter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sys_range_out <= csd_pkg::SYS_RANGE_RST;
      sys_code_out  <= SYS_CODE_W'(csd_pkg::CODE_A_RST);
    end
    else
    begin
      sys_range_out <= sys_range_sel;
      sys_code_out  <= code_a;
    end
  end
endmodule

// [verilog/csd_pkg.sv]
package csd_pkg;
  // timing
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned FAULT_PULSE_US   = 128;
  localparam int unsigned FAULT_PULSE_CYC  = (FAULT_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SOFTSTART_US     = 100;
  localparam int unsigned SOFTSTART_CYC    = (SOFTSTART_US * (CLK_HZ / 1_000_000));
  localparam int unsigned REF_UP_US        = 10;
  localparam int unsigned REF_UP_CYC       = (REF_UP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DISCH_US         = 50;
  localparam int unsigned DISCH_CYC        = (DISCH_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BTN_RESET_MS     = 4;
  localparam int unsigned BTN_RESET_CYC    = (BTN_RESET_MS * (CLK_HZ / 1_000));
  // reset values
  localparam logic [1:0]  SYS_RANGE_RST    = 2'h0;
  localparam logic [3:0]  CODE_A_RST       = 4'h0;
  // buck sequencer states, gray from OFF up to DISCH, two bits change from DISCH back to OFF
  typedef enum logic [2:0] {
    CSD_BK_OFF    = 3'b000,
    CSD_BK_REF    = 3'b001,
    CSD_BK_SOFT   = 3'b011,
    CSD_BK_RUN    = 3'b010,
    CSD_BK_DISCH  = 3'b110
  } csd_buck_st_t;
endpackage

// [verilog/csd_pulse_timer.sv]
// one-shot timer: start loads the count, busy holds while counting down
module csd_pulse_timer #(
  parameter int unsigned CYCLES = 2560,
  parameter int unsigned WIDTH  = 12
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      busy
);
  logic [WIDTH-1:0] cnt_r;  // cycles left

  // refuse a pulse length the counter cannot hold
  if (CYCLES < 1 || CYCLES >= (1 << WIDTH))
  begin
    $error("csd_pulse_timer: CYCLES does not fit WIDTH");
  end

  // restart on every start, even mid pulse
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= '0;
    else if (start)
      cnt_r <= WIDTH'(CYCLES);
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  // busy registered from start and the counter state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy <= 1'b0;
    else
      busy <= start || (cnt_r > 1);
  end
endmodule

// [test/csd_host_model.sv]
// host side: pull-ups on both open-drain lines, times each low stretch on the interrupt line
module csd_host_model (
  input  wire logic        clk,
  input  wire logic        pg_oe,
  input  wire logic        int_oe,
  output logic             pg_level,
  output logic             int_level,
  output logic [15:0]      low_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_r = 16'h0000; // cycles low so far

  // released line floats up through the pull-up, never holds old value
  assign pg_level  = !pg_oe;
  assign int_level = !int_oe;

  // width of the last finished low stretch, seen on release
  always_ff @(posedge clk)
  begin
    if (!int_level)
      run_r <= run_r + 16'h0001;
    else
    begin
      if (run_r != 16'h0000)
        low_len <= run_r;
      run_r <= 16'h0000;
    end
  end
endmodule

// [test/csd_status_ctrl_properties.sv]
// checker for the status and disable controller
module csd_status_chk #(
  parameter int unsigned SYS_CODE_W = 4
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  vin_above_uvlo,
  input wire logic                  vin_above_bat_slp,
  input wire logic                  vin_below_ovp,
  input wire logic                  bat_present,
  input wire logic                  startup_done,
  input wire logic                  startup_fault,
  input wire logic                  charging,
  input wire logic                  recharging,
  input wire logic                  fault_event,
  input wire logic                  safety_timer_fault,
  input wire logic                  pg_mirror_sel,
  input wire logic                  charge_int_en,
  input wire logic                  buck_out_en,
  input wire logic                  button_in_n,
  input wire logic                  chip_disable_n,
  input wire logic                  chip_disable_floating,
  input wire logic [1:0]            sys_range_sel,
  input wire logic [1:0]            sys_range_out,
  input wire logic [SYS_CODE_W-1:0] code_a,
  input wire logic [SYS_CODE_W-1:0] sys_code_out,
  input wire logic                  power_good_n_oe,
  input wire logic                  host_int_n_oe,
  input wire logic                  charge_en,
  input wire logic                  hiz_mode,
  input wire logic                  bat_disch_on,
  input wire logic                  ref_en,
  input wire logic                  soft_start,
  input wire logic                  buck_switch_node_en
);
  logic        seen_r;  // start-up outcome taken
  logic        good_r;  // outcome was good
  logic        good2_r; // one cycle later, outputs settled
  logic [11:0] quiet_r; // cycles since last fault event
  wire win = vin_above_uvlo && vin_above_bat_slp && vin_below_ovp;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // first outcome after reset decides, fault wins a tie
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seen_r  <= 1'b0;
      good_r  <= 1'b0;
      good2_r <= 1'b0;
    end
    else
    begin
      if (!seen_r && (startup_done || startup_fault))
      begin
        seen_r <= 1'b1;
        good_r <= !startup_fault;
      end
      good2_r <= good_r;
    end
  end

  // saturating, so a long quiet spell cannot wrap into a false window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      quiet_r <= 12'h000;
    else if (fault_event || safety_timer_fault)
      quiet_r <= 12'h000;
    else if (quiet_r != 12'hfff)
      quiet_r <= quiet_r + 12'h001;
  end

  no_status_a: assert property (
    ((!good_r && !startup_done) || (seen_r && !good_r)) |=> !power_good_n_oe && !host_int_n_oe)
    else $error("status pin driven without good start-up");
  pg_on_a: assert property (
    good2_r && !pg_mirror_sel && win |=> power_good_n_oe)
    else $error("power good not pulled in window");
  pg_off_a: assert property (
    !pg_mirror_sel && !win |=> !power_good_n_oe)
    else $error("power good pulled outside window");
  pg_mirror_a: assert property (
    good2_r && pg_mirror_sel |=> power_good_n_oe == !$past(button_in_n))
    else $error("power good does not follow button");
  int_charge_a: assert property (
    good2_r && charge_int_en && charge_en && (charging || recharging)
      |=> host_int_n_oe || !charge_en)
    else $error("interrupt not held during charge");
  int_quiet_a: assert property (
    good2_r && quiet_r > 12'h0a0a && !(charge_int_en && (charging || recharging))
      |=> !host_int_n_oe)
    else $error("interrupt pulled with no cause");
  fault_pulse_a: assert property (
    good2_r && fault_event |-> ##2 host_int_n_oe [*8])
    else $error("fault pulse missing");
  hiz_a: assert property (
    bat_present && !vin_above_uvlo && (!chip_disable_n || chip_disable_floating)
      |=> hiz_mode && bat_disch_on)
    else $error("battery-only disable not in high-z");
  charge_off_a: assert property (
    win && chip_disable_n && !chip_disable_floating |=> !charge_en)
    else $error("charge kept with disable high");
  sw_gate_a: assert property (
    !buck_out_en |=> !buck_switch_node_en)
    else $error("switching without enable bit");
  ss_ref_a: assert property (
    $rose(soft_start) |-> $past(ref_en))
    else $error("soft-start before reference");
  vset_a: assert property (
    1'b1 |=> sys_code_out == $past(code_a) && sys_range_out == $past(sys_range_sel))
    else $error("voltage fields not passed on");
endmodule

bind csd_status_ctrl csd_status_chk #(.SYS_CODE_W(SYS_CODE_W)) i_csd_status_chk (.*);

// [test/charger_status_disable_ctrl_tb.sv]
module charger_status_disable_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0;
  logic vin_above_uvlo, vin_above_bat_slp, vin_below_ovp, bat_present, startup_done;
  logic startup_fault, charging, recharging, fault_event, safety_timer_fault;
  logic pg_mirror_sel, charge_int_en, buck_out_en, button_in_n, chip_disable_n;
  logic chip_disable_floating, aux_switch_ctrl, sys_disable_req;
  logic [1:0] sys_range_sel, sys_range_out;
  logic [3:0] code_a, sys_code_out;
  logic power_good_n_o, power_good_n_oe, host_int_n_o, host_int_n_oe, charge_en, hiz_mode;
  logic mid_rail_en, system_rail_en, bat_disch_on, aux_output_en, ref_en, soft_start;
  logic buck_switch_node_en, buck_disch, safety_fault_latched, pg_level, int_level;
  logic [15:0] low_len; // last low stretch on the interrupt wire
  int err_count = 0;
  int checks_done = 0;

  // 20 MHz
  always #25 clk = ~clk;

  // short button hold keeps the run brief
  csd_status_ctrl #(.BTN_RESET_CYCLES(20)) i_csd_status_ctrl (.*);
  csd_host_model i_csd_host_model (.clk(clk), .pg_oe(power_good_n_oe),
    .int_oe(host_int_n_oe), .pg_level(pg_level), .int_level(int_level), .low_len(low_len));

  // inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s ended, mismatches %0d", name, err_count);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well past the planned length of the run
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp, bat_present, startup_done} = '0;
    {startup_fault, charging, recharging, fault_event, safety_timer_fault} = '0;
    {pg_mirror_sel, charge_int_en, buck_out_en, chip_disable_floating} = '0;
    {aux_switch_ctrl, sys_disable_req, sys_range_sel, code_a} = '0;
    button_in_n = 1'b1;
    chip_disable_n = 1'b0;
    step(3);
    reset_n = 1'b1;
    {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp} = 3'b111;
    charging = 1'b1;
    charge_int_en = 1'b1;
    step(3);
    chk(pg_level, 1);
    chk(int_level, 1);
    startup_done = 1'b1;
    step(3);
    chk(pg_level, 0);
    chk(int_level, 0);
    chk(charge_en, 1);
    chk(power_good_n_o, 0);
    chk(host_int_n_o, 0);
    charge_int_en = 1'b0;
    step(2);
    chk(int_level, 1);
    charge_int_en = 1'b1;
    charging = 1'b0;
    recharging = 1'b1;
    step(2);
    chk(int_level, 0);
    chip_disable_n = 1'b1;
    step(3);
    chk(charge_en, 0);
    chk(int_level, 1);
    chip_disable_n = 1'b0;
    recharging = 1'b0;
    step(2);
    chk(int_level, 1);
    done("charge status");
    // each comparator alone drops the window
    for (int k = 0; k < 3; k++)
    begin
      {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp} = 3'b111 ^ (3'b001 << k);
      step(2);
      chk(pg_level, 1);
    end
    {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp} = 3'b111;
    pg_mirror_sel = 1'b1;
    button_in_n = 1'b0;
    step(2);
    chk(pg_level, 0);
    button_in_n = 1'b1;
    step(2);
    chk(pg_level, 1);
    pg_mirror_sel = 1'b0;
    done("power good");
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    step(2700);
    chk(low_len, 16'h0a00);
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    charging = 1'b1;
    step(2700);
    chk(int_level, 0);
    charging = 1'b0;
    safety_timer_fault = 1'b1;
    step(3);
    chk(safety_fault_latched, 1);
    chk(charge_en, 0);
    safety_timer_fault = 1'b0;
    step(2700);
    chk(low_len, 16'h0a00);
    chip_disable_n = 1'b1;
    step(2);
    chip_disable_n = 1'b0;
    step(3);
    chk(safety_fault_latched, 0);
    chk(charge_en, 1);
    done("faults");
    sys_range_sel = 2'h2;
    code_a = 4'h9;
    step(2);
    chk(sys_range_out, 2);
    chk(sys_code_out, 9);
    buck_out_en = 1'b1;
    step(2);
    chk(ref_en, 1);
    step(250);
    chk(soft_start, 1);
    step(2000);
    chk(system_rail_en, 1);
    chk(buck_switch_node_en, 1);
    buck_out_en = 1'b0;
    step(3);
    chk(buck_disch, 1);
    chk(buck_switch_node_en, 0);
    step(1100);
    chk(buck_disch, 0);
    buck_out_en = 1'b1;
    step(2300);
    sys_disable_req = 1'b1;
    step(1);
    sys_disable_req = 1'b0;
    step(3);
    chk(system_rail_en, 0);
    button_in_n = 1'b0;
    step(30);
    button_in_n = 1'b1;
    step(3);
    chk(system_rail_en, 0);
    // rail waits for the discharge to finish, then ramps up again
    step(3200);
    chk(system_rail_en, 1);
    done("buck");
    {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp} = 3'b000;
    bat_present = 1'b1;
    chip_disable_n = 1'b1;
    aux_switch_ctrl = 1'b1;
    step(3);
    chip_disable_n = 1'b0;
    step(3);
    chk(hiz_mode, 1);
    chk(bat_disch_on, 1);
    chk(mid_rail_en, 1);
    chk(system_rail_en, 1);
    chk(aux_output_en, 1);
    aux_switch_ctrl = 1'b0;
    step(2);
    chk(aux_output_en, 0);
    chip_disable_n = 1'b1;
    chip_disable_floating = 1'b1;
    step(2);
    chk(hiz_mode, 1);
    done("chip disable");
    // second reset, start-up ends in a fault
    reset_n = 1'b0;
    startup_done = 1'b0;
    startup_fault = 1'b1;
    {vin_above_uvlo, vin_above_bat_slp, vin_below_ovp} = 3'b111;
    step(2);
    reset_n = 1'b1;
    step(2);
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    step(3);
    chk(int_level, 1);
    chk(pg_level, 1);
    done("start-up fault");
    tally_and_finish();
  end
endmodule
